// File: hdl/atfi_delay_line.sv
// fixed-depth register delay line for the announced frame position
`default_nettype none

module atfi_delay_line #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 1
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_data,
    output logic      [WIDTH-1:0] o_data
);

    logic [WIDTH-1:0] stage_q [DEPTH];

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= i_data;
            for (int i = 1; i < DEPTH; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign o_data = stage_q[DEPTH-1];

endmodule

`default_nettype wire

// File: hdl/atfi_lane_merge.sv
// per-bit merge of aux and direct data into the outgoing frame word, with per-lane error
`default_nettype none

module atfi_lane_merge
    import atfi_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_run,
    input  wire logic [LANES-1:0]  i_ctrl,
    input  wire logic [DATA_W-1:0] i_base,
    input  wire logic [DATA_W-1:0] i_aux_data,
    input  wire logic [DATA_W-1:0] i_aux_mask,
    input  wire logic [DATA_W-1:0] i_dir_data,
    input  wire logic [LANES-1:0]  i_dir_valid,
    output logic      [DATA_W-1:0] o_word_q,
    output logic      [LANES-1:0]  o_err_q
);

    logic [DATA_W-1:0] word_d;
    logic [LANES-1:0]  err_d;

    always_comb begin
        word_d = i_base;
        err_d  = '0;
        for (int l = 0; l < LANES; l++) begin
            // direct data only lands on data lanes
            if (i_dir_valid[l] && !i_ctrl[l]) begin
                word_d[l*8 +: 8] = i_dir_data[l*8 +: 8];
            end
            // any set mask bit over a control byte flags its own lane
            err_d[l] = i_run && i_ctrl[l] && (|i_aux_mask[l*8 +: 8]);
        end
        // mask beats every other source, data passes untouched
        word_d = (i_aux_mask & i_aux_data) | (~i_aux_mask & word_d);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word_q <= '0;
            o_err_q  <= '0;
        end else begin
            o_word_q <= word_d;
            o_err_q  <= err_d;
        end
    end

endmodule

`default_nettype wire

// File: hdl/atfi_pkg.sv
// shared constants, types and frame-position functions of the aux transmit insertion block
`default_nettype none

package atfi_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned LANES   = 4;
    localparam int unsigned SEQ_W   = 6;
    localparam int unsigned X_W     = 8;
    localparam int unsigned Z_W     = 8;
    localparam int unsigned BFN_W   = 12;
    localparam int unsigned POS_W   = SEQ_W + X_W + Z_W;

    // ------------------------------------------------------------
    // frame numbering limits
    // ------------------------------------------------------------
    localparam logic [X_W-1:0]   X_LAST   = 8'hff;
    localparam logic [Z_W-1:0]   Z_LAST   = 8'h95;
    localparam logic [BFN_W-1:0] BFN_LAST = 12'hfff;

    // ------------------------------------------------------------
    // line rates and their per-rate figures
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_0P6144 = 2'h0,
        RATE_1P2288 = 2'h1,
        RATE_2P4576 = 2'h2,
        RATE_6P144  = 2'h3
    } atfi_rate_e;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h08;
    localparam logic [7:0] ADDR_POS     = 8'h0c;
    localparam logic [7:0] ADDR_BFN     = 8'h10;

    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_RATE_LSB   = 1;
    localparam int unsigned CTRL_RESYNC_BIT = 3;

    localparam int unsigned EVT_ERR_BIT = 0;
    localparam int unsigned EVT_HFP_BIT = 1;
    localparam int unsigned EVT_RFP_BIT = 2;
    localparam int unsigned EVT_W       = 3;

    localparam int unsigned POS_SEQ_LSB = 0;
    localparam int unsigned POS_X_LSB   = 8;
    localparam int unsigned POS_Z_LSB   = 16;

    localparam logic [1:0]       CTRL_RST   = 2'h0;
    localparam logic [EVT_W-1:0] IRQ_EN_RST = 3'h0;

    // last sequence value of one basic frame
    function automatic logic [SEQ_W-1:0] seq_last(input atfi_rate_e rate);
        case (rate)
            RATE_0P6144: seq_last = 6'h03;
            RATE_1P2288: seq_last = 6'h07;
            RATE_2P4576: seq_last = 6'h0f;
            default:     seq_last = 6'h27;
        endcase
    endfunction

    // bytes of the control word that opens each basic frame
    function automatic logic [7:0] ctrl_bytes(input atfi_rate_e rate);
        case (rate)
            RATE_0P6144: ctrl_bytes = 8'h01;
            RATE_1P2288: ctrl_bytes = 8'h02;
            RATE_2P4576: ctrl_bytes = 8'h04;
            default:     ctrl_bytes = 8'h0a;
        endcase
    endfunction

    // one bit per lane, bit 3 = bits 31:24 = earliest byte
    function automatic logic [LANES-1:0] ctrl_lanes(input atfi_rate_e rate, input logic [SEQ_W-1:0] seq);
        logic [7:0] idx;
        ctrl_lanes = '0;
        idx = 8'h00;
        for (int l = 0; l < LANES; l++) begin
            idx = {seq, 2'(l)};
            ctrl_lanes[LANES-1-l] = (idx < ctrl_bytes(rate));
        end
    endfunction

endpackage

`default_nettype wire

// File: hdl/aux_tx_frame_insertion.sv
// aux transmit insertion: frame sync, position announce, latency alignment, merge, apb registers
`default_nettype none

module aux_tx_frame_insertion
    import atfi_pkg::*;
#(
    parameter int unsigned P_EXTRA_LAT = 0
) (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst_n,
    // apb slave
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [7:0]                  i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    output logic                             o_irq,
    // aux transmit user side
    output logic      [atfi_pkg::SEQ_W-1:0]  o_aux_seq,
    output logic      [atfi_pkg::X_W-1:0]    o_aux_x,
    output logic      [atfi_pkg::Z_W-1:0]    o_aux_z,
    output logic      [atfi_pkg::BFN_W-1:0]  o_aux_bfn,
    output logic                             o_aux_hfp,
    output logic                             o_aux_rfp,
    output logic      [atfi_pkg::LANES-1:0]  o_aux_ctrl,
    input  wire logic [atfi_pkg::DATA_W-1:0] i_aux_data,
    input  wire logic [atfi_pkg::DATA_W-1:0] i_aux_mask,
    output logic      [atfi_pkg::LANES-1:0]  o_aux_err,
    // direct transmit user side
    output logic      [atfi_pkg::LANES-1:0]  o_dir_ready,
    input  wire logic [atfi_pkg::DATA_W-1:0] i_dir_data,
    input  wire logic [atfi_pkg::LANES-1:0]  i_dir_valid,
    // frame side
    input  wire logic [atfi_pkg::DATA_W-1:0] i_frame_base,
    output logic      [atfi_pkg::DATA_W-1:0] o_frame_word,
    output logic      [atfi_pkg::SEQ_W-1:0]  o_frame_seq,
    output logic                             o_frame_valid
);

    import atfi_pkg::*;

    // one cycle of write latency plus the extra N
    localparam int unsigned ALIGN_DEPTH = 1 + P_EXTRA_LAT;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } atfi_sync_e;

    atfi_sync_e         state_q, state_d;
    logic               en_q;
    atfi_rate_e         rate_q;
    logic               resync_q;
    logic [EVT_W-1:0]   status_q, status_d;
    logic [EVT_W-1:0]   irq_en_q;
    logic [EVT_W-1:0]   evt;
    logic               irq_q;

    logic [SEQ_W-1:0]   seq_q, seq_d;
    logic [X_W-1:0]     x_q, x_d;
    logic [Z_W-1:0]     z_q, z_d;
    logic [BFN_W-1:0]   bfn_q, bfn_d;
    logic               hfp_q, rfp_q;
    logic [LANES-1:0]   ctrl_q;
    logic [LANES-1:0]   dir_ready_q;

    logic [POS_W:0]     pos_now;
    logic [POS_W:0]     pos_dl;
    logic [SEQ_W-1:0]   seq_dl;
    logic               run_dl;
    logic [LANES-1:0]   ctrl_dl;
    logic [SEQ_W-1:0]   frame_seq_q;
    logic               frame_valid_q;

    logic               wr_acc, rd_setup, addr_ok;
    logic [31:0]        rdata_d;
    logic [31:0]        prdata_q;
    logic               pready_q, pslverr_q;

    // ------------------------------------------------------------
    // frame synchronisation state machine
    // ------------------------------------------------------------
    always_comb begin
        case (state_q)
            ST_IDLE: state_d = en_q ? ST_RUN : ST_IDLE;
            ST_RUN:  state_d = en_q ? ST_RUN : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // sequence wraps per basic frame, then basic frame, hyperframe, radio frame
    always_comb begin
        seq_d = seq_q;
        x_d   = x_q;
        z_d   = z_q;
        bfn_d = bfn_q;
        if (state_q != ST_RUN || resync_q) begin
            seq_d = '0;
            x_d   = '0;
            z_d   = '0;
            bfn_d = '0;
        // >= also catches a count above a smaller rate's end
        end else if (seq_q >= seq_last(rate_q)) begin
            seq_d = '0;
            if (x_q == X_LAST) begin
                x_d = '0;
                if (z_q == Z_LAST) begin
                    z_d   = '0;
                    bfn_d = (bfn_q == BFN_LAST) ? '0 : bfn_q + 1'b1;
                end else begin
                    z_d = z_q + 1'b1;
                end
            end else begin
                x_d = x_q + 1'b1;
            end
        end else begin
            seq_d = seq_q + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_q <= '0;
            x_q   <= '0;
            z_q   <= '0;
            bfn_q <= '0;
        end else begin
            seq_q <= seq_d;
            x_q   <= x_d;
            z_q   <= z_d;
            bfn_q <= bfn_d;
        end
    end

    // pulses and lane flags registered alongside the numbers they describe
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hfp_q       <= 1'b0;
            rfp_q       <= 1'b0;
            ctrl_q      <= '0;
            dir_ready_q <= '0;
        end else begin
            hfp_q       <= (state_d == ST_RUN) && (seq_d == '0) && (x_d == '0);
            rfp_q       <= (state_d == ST_RUN) && (seq_d == '0) && (x_d == '0) && (z_d == '0);
            ctrl_q      <= (state_d == ST_RUN) ? ctrl_lanes(rate_q, seq_d) : '0;
            // direct side gets its own ready; data follows after the same latency
            dir_ready_q <= (state_d == ST_RUN) ? ~ctrl_lanes(rate_q, seq_d) : '0;
        end
    end

    // ------------------------------------------------------------
    // write latency alignment
    // ------------------------------------------------------------
    // the position shown now is the one user data answers 1+N cycles later
    assign pos_now = {(state_q == ST_RUN), z_q, x_q, seq_q};

    atfi_delay_line #(
        .WIDTH (POS_W + 1),
        .DEPTH (ALIGN_DEPTH)
    ) u_pos_align (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_data    (pos_now),
        .o_data    (pos_dl)
    );

    // with N zero the word sampled at k+1 lands on position k
    assign seq_dl  = pos_dl[SEQ_W-1:0];
    assign run_dl  = pos_dl[POS_W];
    // lane map uses the live rate: change rate only while idle
    assign ctrl_dl = run_dl ? ctrl_lanes(rate_q, seq_dl) : '0;

    // ------------------------------------------------------------
    // insertion into the outgoing 32-bit frame word
    // ------------------------------------------------------------
    atfi_lane_merge u_merge (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_run       (run_dl),
        .i_ctrl      (ctrl_dl),
        .i_base      (i_frame_base),
        .i_aux_data  (i_aux_data),
        .i_aux_mask  (i_aux_mask),
        .i_dir_data  (i_dir_data),
        .i_dir_valid (i_dir_valid),
        .o_word_q    (o_frame_word),
        .o_err_q     (o_aux_err)
    );

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_seq_q   <= '0;
            frame_valid_q <= 1'b0;
        end else begin
            frame_seq_q   <= seq_dl;
            frame_valid_q <= run_dl;
        end
    end

    // ------------------------------------------------------------
    // apb slave: one access-phase cycle, read data registered
    // ------------------------------------------------------------
    // a write lands only in the answered access cycle
    assign wr_acc   = i_psel && i_penable && pready_q && i_pwrite;
    assign rd_setup = i_psel && !i_penable;

    always_comb begin
        addr_ok = 1'b1;
        rdata_d = '0;
        case (i_paddr)
            ADDR_CTRL: begin
                rdata_d[CTRL_EN_BIT]                  = en_q;
                rdata_d[CTRL_RATE_LSB +: 2]           = rate_q;
            end
            ADDR_STATUS: rdata_d[EVT_W-1:0] = status_q;
            ADDR_IRQ_EN: rdata_d[EVT_W-1:0] = irq_en_q;
            ADDR_POS: begin
                rdata_d[POS_SEQ_LSB +: SEQ_W] = seq_q;
                rdata_d[POS_X_LSB +: X_W]     = x_q;
                rdata_d[POS_Z_LSB +: Z_W]     = z_q;
            end
            ADDR_BFN:    rdata_d[BFN_W-1:0] = bfn_q;
            default:     addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= rd_setup;
            pslverr_q <= rd_setup && !addr_ok;
            prdata_q  <= (rd_setup && !i_pwrite) ? rdata_d : '0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q     <= 1'b0;
            rate_q   <= RATE_0P6144;
            resync_q <= 1'b0;
            irq_en_q <= IRQ_EN_RST;
        end else begin
            // resync is a self-clearing command bit
            resync_q <= wr_acc && (i_paddr == ADDR_CTRL) && i_pwdata[CTRL_RESYNC_BIT];
            if (wr_acc && i_paddr == ADDR_CTRL) begin
                en_q   <= i_pwdata[CTRL_EN_BIT];
                rate_q <= atfi_rate_e'(i_pwdata[CTRL_RATE_LSB +: 2]);
            end
            if (wr_acc && i_paddr == ADDR_IRQ_EN) begin
                irq_en_q <= i_pwdata[EVT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sticky events and interrupt
    // ------------------------------------------------------------
    assign evt[EVT_ERR_BIT] = |o_aux_err;
    assign evt[EVT_HFP_BIT] = hfp_q;
    assign evt[EVT_RFP_BIT] = rfp_q;

    // a new event in the clearing cycle survives the clear
    always_comb begin
        status_d = status_q;
        if (wr_acc && i_paddr == ADDR_STATUS) begin
            status_d = status_q & ~i_pwdata[EVT_W-1:0];
        end
        status_d = status_d | evt;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            // from status_d so irq rises with the sticky bit
            irq_q    <= |(status_d & irq_en_q);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_prdata      = prdata_q;
    assign o_pready      = pready_q;
    assign o_pslverr     = pslverr_q;
    assign o_irq         = irq_q;
    assign o_aux_seq     = seq_q;
    assign o_aux_x       = x_q;
    assign o_aux_z       = z_q;
    assign o_aux_bfn     = bfn_q;
    assign o_aux_hfp     = hfp_q;
    assign o_aux_rfp     = rfp_q;
    assign o_aux_ctrl    = ctrl_q;
    assign o_dir_ready   = dir_ready_q;
    assign o_frame_seq   = frame_seq_q;
    assign o_frame_valid = frame_valid_q;

endmodule

`default_nettype wire

// File: verif/atfi_chk.sv
// assertion checker bound to the aux transmit insertion block
`default_nettype none
module atfi_chk
    import atfi_pkg::*;
#(
    parameter int unsigned P_EXTRA_LAT = 0
) (
    input wire logic                        i_sys_clk,
    input wire logic                        i_rst_n,
    input wire logic                        i_psel,
    input wire logic                        i_penable,
    input wire logic                        o_pready,
    input wire logic                        o_pslverr,
    input wire logic [atfi_pkg::DATA_W-1:0] i_aux_mask,
    input wire logic [atfi_pkg::SEQ_W-1:0]  o_aux_seq,
    input wire logic [atfi_pkg::X_W-1:0]    o_aux_x,
    input wire logic [atfi_pkg::Z_W-1:0]    o_aux_z,
    input wire logic                        o_aux_hfp,
    input wire logic                        o_aux_rfp,
    input wire logic [atfi_pkg::LANES-1:0]  o_aux_ctrl,
    input wire logic [atfi_pkg::LANES-1:0]  o_aux_err,
    input wire logic [atfi_pkg::LANES-1:0]  o_dir_ready,
    input wire logic                        o_frame_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    logic [3:0] mask_lanes;
    assign mask_lanes = {|i_aux_mask[31:24], |i_aux_mask[23:16], |i_aux_mask[15:8], |i_aux_mask[7:0]};
    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    apb_answer_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no answer after setup");
    apb_single_a: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
    slverr_with_a: assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
    // gated so start-up cycles with a stale announce are not judged
    err_lane_a: assert property (o_frame_valid && $past(o_frame_valid, P_EXTRA_LAT + 2) |->
        o_aux_err == ($past(mask_lanes) & $past(o_aux_ctrl, P_EXTRA_LAT + 2))) else $error("lane error wrong");
    idle_err_a: assert property (!o_frame_valid && !$past(o_frame_valid) |-> o_aux_err == 4'h0) else $error("error idle");
    ctrl_first_a: assert property ((o_aux_ctrl | o_dir_ready) == 4'hf && o_aux_seq == 6'h00
        |-> o_aux_ctrl[3]) else $error("first lane not control");
    ctrl_late_a: assert property (o_aux_seq > 6'h02 |-> o_aux_ctrl == 4'h0) else $error("control late");
    ready_free_a: assert property (o_dir_ready != 4'h0 && o_aux_seq > 6'h02 |-> o_dir_ready == 4'hf)
        else $error("direct lanes not ready");
    seq_step_a: assert property (o_frame_valid && $past(o_frame_valid) && o_aux_seq != 6'h00
        |-> o_aux_seq == $past(o_aux_seq) + 6'h01) else $error("sequence skipped");
    hfp_pos_a: assert property (o_aux_hfp |-> o_aux_seq == 6'h00 && o_aux_x == 8'h00)
        else $error("hfp off position");
    rfp_pos_a: assert property (o_aux_rfp |-> o_aux_hfp && o_aux_z == 8'h00) else $error("rfp off");
endmodule
bind aux_tx_frame_insertion atfi_chk #(.P_EXTRA_LAT(P_EXTRA_LAT)) i_atfi_chk (.i_sys_clk, .i_rst_n, .i_psel,
    .i_penable, .o_pready, .o_pslverr, .i_aux_mask, .o_aux_seq, .o_aux_x, .o_aux_z, .o_aux_hfp, .o_aux_rfp,
    .o_aux_ctrl, .o_aux_err, .o_dir_ready, .o_frame_valid);
`default_nettype wire

// File: verif/atfi_user_model.sv
// behavioural user logic driving the aux transmit word and mask
`default_nettype none
module atfi_user_model #(
    parameter int unsigned LAT = 0
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_ctrl,
    input  wire logic        i_err_mode,
    output logic      [31:0] o_data,
    output logic      [31:0] o_mask
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // delayed announce and word drive
    // ------------------------------------------------------------
    logic [3:0]  hist [LAT+1];
    logic [3:0]  due;
    logic [31:0] keep;
    // announce held back by the configured extra latency
    assign due = (LAT == 0) ? i_ctrl : hist[(LAT == 0) ? 0 : LAT - 1];
    // control lanes left alone unless a fault is commanded
    assign keep = i_err_mode ? 32'hffffffff : ~{{8{due[3]}}, {8{due[2]}}, {8{due[1]}}, {8{due[0]}}};
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k <= LAT; k++) hist[k] <= 4'h0;
        end else begin
            hist[0] <= i_ctrl;
            for (int k = 1; k <= LAT; k++) hist[k] <= hist[k-1];
        end
        // earliest byte in 31:24, any checksum already inside
        o_data <= $urandom;
        o_mask <= $urandom & keep;
    end
endmodule
`default_nettype wire

// File: verif/aux_tx_frame_insertion_bench.sv
// self-checking bench of the aux transmit insertion block with a reference model
`default_nettype none
module aux_tx_frame_insertion_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import atfi_pkg::*;
    localparam int unsigned N = 1;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, hfp, rfp, fvalid, err_mode, live, er;
    logic [7:0]  paddr, ax, az;
    logic [31:0] pwdata, prdata, adata, amask, ddata, base, fword, e_word, rd;
    logic [11:0] bfn;
    logic [5:0]  seq, fseq, e_fseq, prev_seq;
    logic [3:0]  ctrl, aerr, dready, dvalid, c_old, e_err;
    logic [3:0]  cq[$];
    logic [5:0]  sq[$];
    int          cb[4] = '{1, 2, 4, 10};
    int          lastq[4] = '{3, 7, 15, 39};
    int          rate, fails, check_count, cyc;

    aux_tx_frame_insertion #(.P_EXTRA_LAT(N)) i_aux_tx_frame_insertion (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_aux_seq(seq), .o_aux_x(ax),
        .o_aux_z(az), .o_aux_bfn(bfn), .o_aux_hfp(hfp), .o_aux_rfp(rfp), .o_aux_ctrl(ctrl), .i_aux_data(adata),
        .i_aux_mask(amask), .o_aux_err(aerr), .o_dir_ready(dready), .i_dir_data(ddata), .i_dir_valid(dvalid),
        .i_frame_base(base), .o_frame_word(fword), .o_frame_seq(fseq), .o_frame_valid(fvalid));
    atfi_user_model #(.LAT(N)) i_atfi_user_model (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_ctrl(ctrl),
        .i_err_mode(err_mode), .o_data(adata), .o_mask(amask));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] lanes_of(logic [5:0] s);
        lanes_of = 4'h0;
        for (int l = 0; l < 4; l++) lanes_of[3-l] = (4 * s + l < cb[rate]);
    endfunction
    function automatic logic [31:0] wide(logic [3:0] c);
        wide = {{8{c[3]}}, {8{c[2]}}, {8{c[1]}}, {8{c[0]}}};
    endfunction
    task automatic cmp(input logic [31:0] a, input logic [31:0] e, input string m);
        check_count++;
        if (a !== e) begin
            fails++;
            $display("FAIL %0t %s got %h exp %h", $time, m, a, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // clock, stimulus, reference model
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc >= 20000) begin
            fails++;
            summarize();
        end
    end
    always @(posedge sys_clk) begin
        ddata <= $urandom;
        dvalid <= $urandom;
        base <= $urandom;
    end
    // previous edge's prediction is judged before the next one is formed
    always @(posedge sys_clk) begin
        if (live) begin
            cmp(fword, e_word, "frame word");
            cmp(aerr, e_err, "lane error");
            cmp(fseq, e_fseq, "frame seq");
            cmp(ctrl, lanes_of(seq), "ctrl lanes");
            cmp(dready, 4'(~lanes_of(seq)), "direct ready");
            cmp(seq, (prev_seq == lastq[rate]) ? 6'h00 : prev_seq + 6'h01, "sequence");
            cmp(bfn, 32'h0, "radio frame");
        end
        prev_seq = seq;
        cq.push_back(lanes_of(seq));
        sq.push_back(seq);
        if (cq.size() > N + 1) begin
            c_old = cq.pop_front();
            e_fseq = sq.pop_front();
        end
        e_word = (adata & amask) | (~amask & ((ddata & wide(dvalid & ~c_old)) | (base & ~wide(dvalid & ~c_old))));
        e_err = c_old & {|amask[31:24], |amask[23:16], |amask[15:8], |amask[7:0]};
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ddata, dvalid, base, err_mode, live} = '0;
        {fails, check_count, cyc, rate} = '0;
        void'($urandom(68));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        cmp(rd, 32'h0, "ctrl reset");
        apb(1'b0, ADDR_IRQ_EN, 32'h0);
        cmp(rd, 32'h0, "irq enable reset");
        apb(1'b0, 8'h14, 32'h0);
        cmp({31'h0, er}, 32'h1, "unmapped error");
        cmp(rd, 32'h0, "unmapped data");
        for (int r = 0; r < 4; r++) begin
            live <= 1'b0;
            apb(1'b1, ADDR_CTRL, 32'(rate << 1));
            apb(1'b1, ADDR_CTRL, 32'(r << 1) | 32'h8);
            rate = r;
            apb(1'b1, ADDR_CTRL, 32'(r << 1) | 32'h1);
            apb(1'b1, ADDR_IRQ_EN, 32'h1);
            repeat (12) @(posedge sys_clk);
            live <= 1'b1;
            repeat (1100) @(posedge sys_clk);
            err_mode <= 1'b1;
            repeat (40) @(posedge sys_clk);
            err_mode <= 1'b0;
            @(negedge sys_clk);
            cmp({31'h0, irq}, 32'h1, "irq raised");
            apb(1'b1, ADDR_IRQ_EN, 32'h0);
            repeat (2) @(negedge sys_clk);
            cmp({31'h0, irq}, 32'h0, "irq masked");
            apb(1'b1, ADDR_STATUS, 32'h7);
            apb(1'b0, ADDR_STATUS, 32'h0);
            cmp({31'h0, rd[EVT_ERR_BIT]}, 32'h0, "status cleared");
            apb(1'b1, ADDR_IRQ_EN, 32'h1);
            @(negedge sys_clk);
            cmp({31'h0, irq}, 32'h0, "irq cleared");
            $display("test rate %0d done", r);
        end
        summarize();
    end
endmodule
`default_nettype wire
